/* File: design/fpec_pkg.sv */
// package: register map, field positions and reset values for the flash control block
package fpec_pkg;
  // register indices on the plain register port
  localparam logic [2:0] FPEC_ADDR_MODE   = 3'h0;
  localparam logic [2:0] FPEC_ADDR_STATUS = 3'h1;
  localparam logic [2:0] FPEC_ADDR_BLOCK  = 3'h2;
  localparam logic [2:0] FPEC_ADDR_ACCESS = 3'h3;
  localparam logic [2:0] FPEC_ADDR_IRQ_ST = 3'h4;
  localparam logic [2:0] FPEC_ADDR_IRQ_MK = 3'h5;
  // mode control fields
  localparam int FPEC_BIT_RSVD   = 7;
  localparam int FPEC_BIT_WR_EN       = 6;
  localparam int FPEC_BIT_ERASE_SETUP = 5;
  localparam int FPEC_BIT_PROG_SETUP  = 4;
  localparam int FPEC_BIT_ERASE_VFY   = 3;
  localparam int FPEC_BIT_PROG_VFY    = 2;
  localparam int FPEC_BIT_ERASE  = 1;
  localparam int FPEC_BIT_PROG   = 0;
  // status / access fields, block select width
  localparam int FPEC_BIT_ERR_FLAG = 7;
  localparam int FPEC_BIT_ACC_EN   = 7;
  localparam int FPEC_BLOCK_W    = 5;
  // interrupt status fields
  localparam int FPEC_IRQ_ERROR  = 0;
  localparam int FPEC_IRQ_ERASE  = 1;
  localparam int FPEC_IRQ_PROG   = 2;
  localparam int FPEC_IRQ_W      = 3;
  // reset values
  localparam logic [7:0] FPEC_MODE_RST   = 8'h00;
  localparam logic [7:0] FPEC_STATUS_RST = 8'h00;
  localparam logic [7:0] FPEC_BLOCK_RST  = 8'h00;
  localparam logic [7:0] FPEC_ACCESS_RST = 8'h00;
  localparam logic [2:0] FPEC_IRQ_RST    = 3'h0;
  // flash operating state reported to the array
  typedef enum logic [2:0] {
    FPEC_ST_IDLE  = 3'b000,
    FPEC_ST_ERASE_SETUP = 3'b001,
    FPEC_ST_PROG_SETUP  = 3'b010,
    FPEC_ST_ERASE = 3'b011,
    FPEC_ST_PROG  = 3'b100,
    FPEC_ST_EVER  = 3'b101,
    FPEC_ST_PVER  = 3'b110,
    FPEC_ST_PROT  = 3'b111
  } fpec_state_t;
endpackage

/* File: design/fpec_irq_if.sv */
// interface: event and mask path between the core and its interrupt unit
`timescale 1ns/1ns
interface fpec_irq_if;
  logic [2:0] events;
  logic [2:0] wr_clear;
  logic [2:0] wr_mask;
  logic       mask_we;
  logic [2:0] status;
  logic [2:0] mask;
  logic       irq;
  modport core (output events, output wr_clear, output wr_mask, output mask_we,
                input status, input mask, input irq);
  modport unit (input events, input wr_clear, input wr_mask, input mask_we,
                output status, output mask, output irq);
endinterface

/* File: design/fpec_irq.sv */
// sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ns
module fpec_irq
  import fpec_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  fpec_irq_if.unit  bus
);
  logic [2:0] status_reg, status_next;
  logic [2:0] mask_reg, mask_next;
  logic       irq_reg, irq_next;

  // set wins over a clear in the same cycle
  // a mask bit of one blocks its source; all sources open after reset
  always_comb begin
    status_next = (status_reg & ~bus.wr_clear) | bus.events;
    mask_next   = bus.mask_we ? bus.wr_mask : mask_reg;
    irq_next    = |(status_next & ~mask_next);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= FPEC_IRQ_RST;
      mask_reg   <= FPEC_IRQ_RST;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign bus.status = status_reg;
  assign bus.mask   = mask_reg;
  assign bus.irq    = irq_reg;
endmodule // fpec_irq

/* File: design/fpec_ctrl.sv */
// flash program/erase control: mode, status, block select, access enable
//
// Function
// - reserved mode bit 7 always reads zero.
// - programming and erasing allowed only while soft_write_enable is one.
// - with soft_write_enable zero, other mode bits and block bits cannot be set.
// - erase_setup bit 5 enters erase setup state; clearing leaves it.
// - program_setup bit 4 enters program setup state; clearing cancels it.
// - erase_verify bit 3 enters erase-verify mode; clearing cancels it.
// - program_verify bit 2 enters program-verify mode; clearing cancels it.
// - erase bit 1 with enable and erase_setup enters erase mode.
// - program bit 0 with enable and program_setup enters program mode.
// - status register is read-only; software does not write it.
// - flash_error_flag bit 7 sets on an error during program or erase.
// - while flash_error_flag is one, flash is held in error protection.
// - status bits 6 to 0 always read zero.
// - erase_block_select is held at zero while soft_write_enable is zero.
// - control registers accessible only while ctrl_reg_access_enable is one.
//
// register indices on the plain port
//   0 mode control: enable, setups, verifies, erase, program
//   1 program status: error flag in the top bit, the rest zero
//   2 erase block select: one-hot, five blocks
//   3 access enable: top bit opens indices 0 to 2
//   4 interrupt status: sticky, write one to clear
//   5 interrupt mask: a one blocks that source
//
// timing seen from the port
//   write strobe sampled on a rising edge, register holds it from then
//   read data registered, stands only in the cycle after the strobe
//   flash_state follows the mode register one cycle later
//   error input crosses two flops, so the flag lags it by three edges
//
// limitations
//   no program or erase timing here; software owns the pulse lengths
//   the error flag clears only on reset, never by a register write
//   setup and operate bits may arrive in one write; the state still
//   needs both, so a lone operate bit leaves the array idle
`timescale 1ns/1ns
module fpec_ctrl
  import fpec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       flash_error_in,
  output logic      [2:0] flash_state,
  output logic      [4:0] erase_block_out,
  output logic            irq
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  mode_reg, mode_next;
  logic        err_flag_reg, err_flag_next;
  logic [4:0]  block_reg, block_next;
  logic        access_reg, access_next;
  logic        err_sync1_reg, err_sync2_reg;
  logic [7:0]  rdata_reg, rdata_next;
  fpec_state_t state_reg, state_next;
  logic [4:0]  blk_out_reg, blk_out_next;
  logic        erase_act, prog_act;
  logic        wr_mode, wr_block, ctrl_ok;
  fpec_irq_if  ib ();

  fpec_irq u_irq (
    .clk (clk),
    .rst (rst),
    .bus (ib.unit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode; control registers gated by the access enable
  // a stray write while closed is dropped here, before any field sees it
  always_comb begin
    ctrl_ok  = access_reg;
    wr_mode  = reg_wr && ctrl_ok && (reg_addr == FPEC_ADDR_MODE);
    wr_block = reg_wr && ctrl_ok && (reg_addr == FPEC_ADDR_BLOCK);
  end

  // mode register update; enable bit itself is writable whenever access is open
  // a write with the enable low wipes every other bit, so software
  // cannot park a setup or operate bit while the array is locked
  always_comb begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = reg_wdata;
      mode_next[FPEC_BIT_RSVD] = 1'b0;
      if (!reg_wdata[FPEC_BIT_WR_EN])
        mode_next = FPEC_MODE_RST;
    end
    // second guard keeps the register clean whatever the write path did
    if (!mode_next[FPEC_BIT_WR_EN])
      mode_next = FPEC_MODE_RST;
  end

  // block select cleared on enable low; more than one bit set clears all
  // two blocks at once would erase an unintended area, so the whole
  // select drops to zero instead of picking one of them
  always_comb begin
    block_next = block_reg;
    if (wr_block)
      block_next = reg_wdata[FPEC_BLOCK_W-1:0];
    if ((block_next & (block_next - 5'h01)) != 5'h00)
      block_next = 5'h00;
    if (!mode_next[FPEC_BIT_WR_EN])
      block_next = 5'h00;
  end

  // access enable register, always reachable
  // it must stay open to writes, or a closed block could never reopen
  always_comb begin
    access_next = access_reg;
    if (reg_wr && reg_addr == FPEC_ADDR_ACCESS)
      access_next = reg_wdata[FPEC_BIT_ACC_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // active operations need enable plus matching setup
  // built from the registered mode, so they change one edge after a write
  always_comb begin
    erase_act = mode_reg[FPEC_BIT_WR_EN] && mode_reg[FPEC_BIT_ERASE_SETUP] &&
                mode_reg[FPEC_BIT_ERASE];
    prog_act  = mode_reg[FPEC_BIT_WR_EN] && mode_reg[FPEC_BIT_PROG_SETUP] &&
                mode_reg[FPEC_BIT_PROG];
  end

  // error flag sets during an active operation; only reset clears it
  // no write path reaches it, so a status write cannot hide a failure
  always_comb begin
    err_flag_next = err_flag_reg | (err_sync2_reg & (erase_act | prog_act));
  end

  // flash state priority: protection, operations, verify, setup
  // protection outranks everything, so no mode write can restart the
  // array after a failure; an operation outranks its own setup bit
  always_comb begin
    state_next = FPEC_ST_IDLE;
    if (err_flag_reg)
      state_next = FPEC_ST_PROT;
    else if (!mode_reg[FPEC_BIT_WR_EN])
      state_next = FPEC_ST_IDLE;
    else if (erase_act)
      state_next = FPEC_ST_ERASE;
    else if (prog_act)
      state_next = FPEC_ST_PROG;
    else if (mode_reg[FPEC_BIT_ERASE_VFY])
      state_next = FPEC_ST_EVER;
    else if (mode_reg[FPEC_BIT_PROG_VFY])
      state_next = FPEC_ST_PVER;
    else if (mode_reg[FPEC_BIT_ERASE_SETUP])
      state_next = FPEC_ST_ERASE_SETUP;
    else if (mode_reg[FPEC_BIT_PROG_SETUP])
      state_next = FPEC_ST_PROG_SETUP;
  end

  // block select seen by the array; dropped while locked or protected
  // so a stale select never reaches an erase after an error
  always_comb begin
    blk_out_next = block_reg;
    if (err_flag_reg || !mode_reg[FPEC_BIT_WR_EN])
      blk_out_next = 5'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped or locked registers read zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        FPEC_ADDR_MODE:   rdata_next = ctrl_ok ? mode_reg : 8'h00;
        FPEC_ADDR_STATUS: rdata_next = ctrl_ok ? {err_flag_reg, 7'h00} : 8'h00;
        FPEC_ADDR_BLOCK:  rdata_next = ctrl_ok ? {3'h0, block_reg} : 8'h00;
        FPEC_ADDR_ACCESS: rdata_next = {access_reg, 7'h00};
        FPEC_ADDR_IRQ_ST: rdata_next = {5'h00, ib.status};
        FPEC_ADDR_IRQ_MK: rdata_next = {5'h00, ib.mask};
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  // interrupt events: error rising, erase entry, program entry
  always_comb begin
    ib.events = 3'h0;
    ib.events[FPEC_IRQ_ERROR] = err_flag_next & ~err_flag_reg;
    ib.events[FPEC_IRQ_ERASE] = (state_next == FPEC_ST_ERASE) &&
                                (state_reg != FPEC_ST_ERASE);
    ib.events[FPEC_IRQ_PROG]  = (state_next == FPEC_ST_PROG) &&
                                (state_reg != FPEC_ST_PROG);
    ib.wr_clear = (reg_wr && reg_addr == FPEC_ADDR_IRQ_ST) ? reg_wdata[2:0] : 3'h0;
    ib.mask_we  = reg_wr && (reg_addr == FPEC_ADDR_IRQ_MK);
    ib.wr_mask  = reg_wdata[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; error input is from outside, so two flops first
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg      <= FPEC_MODE_RST;
      err_flag_reg  <= FPEC_STATUS_RST[FPEC_BIT_ERR_FLAG];
      block_reg     <= FPEC_BLOCK_RST[4:0];
      access_reg    <= FPEC_ACCESS_RST[FPEC_BIT_ACC_EN];
      err_sync1_reg <= 1'b0;
      err_sync2_reg <= 1'b0;
      rdata_reg     <= 8'h00;
      state_reg     <= FPEC_ST_IDLE;
      blk_out_reg   <= 5'h00;
    end else begin
      mode_reg      <= mode_next;
      err_flag_reg  <= err_flag_next;
      block_reg     <= block_next;
      access_reg    <= access_next;
      err_sync1_reg <= flash_error_in;
      err_sync2_reg <= err_sync1_reg;
      rdata_reg     <= rdata_next;
      state_reg     <= state_next;
      blk_out_reg   <= blk_out_next;
    end
  end

  assign reg_rdata       = rdata_reg;
  assign flash_state     = state_reg;
  assign erase_block_out = blk_out_reg;
  assign irq             = ib.irq;
endmodule // fpec_ctrl

/* File: testbench/fpec_ctrl_monitor.sv */
// checker: port-level properties of the flash control block
`timescale 1ns/1ns
module fpec_ctrl_monitor
  import fpec_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       flash_error_in,
  input wire logic [2:0] flash_state,
  input wire logic [4:0] erase_block_out,
  input wire logic       irq
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_rsvd;
    $past(reg_rd) && $past(reg_addr) == FPEC_ADDR_MODE |-> !reg_rdata[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("mode bit 7 read as one");
  property p_stat;
    $past(reg_rd) && $past(reg_addr) == FPEC_ADDR_STATUS |-> reg_rdata[6:0] == 7'h00;
  endproperty
  a_stat: assert property (p_stat) else $error("status low bits not zero");
  property p_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
  property p_one;
    $onehot0(erase_block_out);
  endproperty
  a_one: assert property (p_one) else $error("several blocks selected");
  property p_hold;
    flash_state == FPEC_ST_PROT |=> flash_state == FPEC_ST_PROT;
  endproperty
  a_hold: assert property (p_hold) else $error("left protection");
  property p_pblk;
    flash_state == FPEC_ST_PROT [*2] |-> erase_block_out == 5'h00;
  endproperty
  a_pblk: assert property (p_pblk) else $error("block select in protection");
  // sync delay plus flag and state registers fit within the window;
  // four samples are all a single error pulse can show before the state moves
  property p_err;
    (flash_error_in && (flash_state == FPEC_ST_ERASE || flash_state == FPEC_ST_PROG)) [*3]
      |-> ##[0:4] flash_state == FPEC_ST_PROT;
  endproperty
  a_err: assert property (p_err) else $error("error did not protect");
  property p_cause;
    $changed(flash_state) && $past(flash_state) != FPEC_ST_PROT
      && flash_state != FPEC_ST_PROT |-> $past(reg_wr, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("state moved without a write");
endmodule // fpec_ctrl_monitor

bind fpec_ctrl fpec_ctrl_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_error_in(flash_error_in), .flash_state(flash_state),
  .erase_block_out(erase_block_out), .irq(irq));

/* File: testbench/flash_program_erase_control_tb.sv */
// testbench: random and directed register traffic for the flash control block
`timescale 1ns/1ns
module flash_program_erase_control_tb;
  import fpec_pkg::*;
  logic       clk, rst, reg_wr, reg_rd, flash_error_in, irq;
  logic [2:0] reg_addr, flash_state;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [4:0] erase_block_out;
  integer     fails = 0, compares = 0, seed = 55, i;
  logic [7:0] modes [9] = '{8'hE0, 8'h50, 8'h48, 8'h44, 8'h62, 8'h51, 8'h42, 8'h41, 8'h3F};

  fpec_ctrl u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_error_in(flash_error_in),
    .flash_state(flash_state), .erase_block_out(erase_block_out), .irq(irq));
  ////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // state priority: erase, program, verifies, then setups
  function automatic logic [2:0] exp_state(input logic [7:0] m);
    if (!m[6]) return FPEC_ST_IDLE;
    if (m[1] && m[5]) return FPEC_ST_ERASE;
    if (m[0] && m[4]) return FPEC_ST_PROG;
    if (m[3]) return FPEC_ST_EVER;
    if (m[2]) return FPEC_ST_PVER;
    if (m[5]) return FPEC_ST_ERASE_SETUP;
    if (m[4]) return FPEC_ST_PROG_SETUP;
    return FPEC_ST_IDLE;
  endfunction
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, reg_wr, reg_rd, flash_error_in, reg_addr, reg_wdata} = {1'b1, 14'h0000};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(FPEC_ADDR_MODE, 8'h70);
    wr(FPEC_ADDR_ACCESS, 8'hFF);
    rd(FPEC_ADDR_ACCESS, 8'h80);
    rd(FPEC_ADDR_MODE, 8'h00);
    rd(3'h7, 8'h00);
    wr(FPEC_ADDR_BLOCK, 8'h01);
    rd(FPEC_ADDR_BLOCK, 8'h00);
    $display("test access done");
    for (i = 0; i < 30; i++) begin
      d = (i < 9) ? modes[i] : 8'($random(seed));
      wr(FPEC_ADDR_MODE, d & 8'hFC);
      wr(FPEC_ADDR_MODE, d);
      rd(FPEC_ADDR_MODE, d[6] ? (d & 8'h7F) : 8'h00);
      chk({5'h00, flash_state}, {5'h00, exp_state(d)});
    end
    $display("test modes done");
    wr(FPEC_ADDR_MODE, 8'h40);
    wr(FPEC_ADDR_BLOCK, 8'h04);
    rd(FPEC_ADDR_BLOCK, 8'h04);
    chk({3'h0, erase_block_out}, 8'h04);
    wr(FPEC_ADDR_BLOCK, 8'h06);
    rd(FPEC_ADDR_BLOCK, 8'h00);
    wr(FPEC_ADDR_BLOCK, 8'h10);
    wr(FPEC_ADDR_MODE, 8'h00);
    rd(FPEC_ADDR_BLOCK, 8'h00);
    wr(FPEC_ADDR_STATUS, 8'hFF);
    rd(FPEC_ADDR_STATUS, 8'h00);
    $display("test block done");
    rd(FPEC_ADDR_IRQ_ST, 8'h06);
    chk({7'h00, irq}, 8'h01);
    wr(FPEC_ADDR_IRQ_MK, 8'h07);
    rd(FPEC_ADDR_IRQ_MK, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wr(FPEC_ADDR_IRQ_MK, 8'h00);
    wr(FPEC_ADDR_IRQ_ST, 8'h06);
    rd(FPEC_ADDR_IRQ_ST, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test irq done");
    wr(FPEC_ADDR_MODE, 8'h60);
    wr(FPEC_ADDR_MODE, 8'h62);
    flash_error_in <= 1'b1;
    for (i = 0; i < 12 && flash_state !== FPEC_ST_PROT; i++) @(negedge clk);
    chk({5'h00, flash_state}, {5'h00, FPEC_ST_PROT});
    if (flash_state !== FPEC_ST_PROT) complete_run();
    @(posedge clk);
    flash_error_in <= 1'b0;
    rd(FPEC_ADDR_STATUS, 8'h80);
    wr(FPEC_ADDR_MODE, 8'h60);
    rd(FPEC_ADDR_IRQ_ST, 8'h03);
    chk({5'h00, flash_state}, {5'h00, FPEC_ST_PROT});
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(FPEC_ADDR_ACCESS, 8'h80);
    rd(FPEC_ADDR_STATUS, 8'h00);
    wr(FPEC_ADDR_MODE, 8'h40);
    wr(FPEC_ADDR_ACCESS, 8'h00);
    rd(FPEC_ADDR_MODE, 8'h00);
    wr(FPEC_ADDR_ACCESS, 8'h80);
    rd(FPEC_ADDR_MODE, 8'h40);
    $display("test error done");
    complete_run();
  end
endmodule // flash_program_erase_control_tb
